// ### key_slot_consts.vh
// Constants for the key slot access control block.
// Assumes a 12-bit infopage byte address and a byte-addressed register port.
`ifndef KEY_SLOT_CONSTS_VH
`define KEY_SLOT_CONSTS_VH

// Unit register offsets (byte addresses)
`define REG_TASK_PUSH 8'h00
`define REG_STATUS 8'h04
`define REG_INT_MASK 8'h08
`define REG_SLOT_SELECT 8'h0C

// Status and mask bit positions
`define ST_BLOCKED 0
`define ST_SELECTED 1
`define ST_PUSH_DONE 2
`define ST_W 3

// Infopage layout
`define OTP_TAG 4'h0
`define HDR_TAG 2'h1
`define OTP_WORDS 64
`define SLOTS 128
`define VALUE_WORDS 512
`define KEY_WORDS 4

// Slot permission bits
`define SLOT_PERMISSIONS_WRITE 0
`define SLOT_PERMISSIONS_READ 1
`define SLOT_PERMISSIONS_PUSH 2
`define SLOT_PERMISSIONS_ACTIVE 16

// Fixed values
`define ERASED_WORD 32'hFFFF_FFFF
`define ERASED_HALF 16'hFFFF
`define BLOCKED_WORD 32'hDEAD_DEAD
`define ZERO_WORD 32'h0000_0000
`define SEL_NONE 8'h00
`define SEL_ONE 8'h01
`define SEL_MAX 8'h80
`define PUSH_LAST 2'h3
`define PUSH_FIRST 2'h0
`define PUSH_STEP 2'h1
`define ADDR_STEP 32'h0000_0004

`endif

// ### key_slot_access_control.v
// Access control for the configuration infopage: OTP region and 128 key slots,
// plus the key push engine and the unit's own register port.
// Assumes one clock, synchronous low reset, and a single infopage access per cycle.
//
// Local design decisions: the register addresses and the plain strobed port.
`include "key_slot_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module key_slot_access_control (
  input wire clk_i,
  input wire rst_n_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  input wire reg_secure_i,
  output reg [31:0] reg_rdata_o,
  input wire [11:0] ip_addr_i,
  input wire [31:0] ip_wdata_i,
  input wire ip_we_i,
  input wire ip_re_i,
  input wire ip_secure_i,
  output reg [31:0] ip_rdata_o,
  output reg push_valid_o,
  output reg [31:0] push_addr_o,
  output reg [31:0] push_data_o,
  output reg irq_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_PUSH = 1'b1;

  // Infopage regions
  localparam RG_NONE = 2'h0;
  localparam RG_OTP = 2'h1;
  localparam RG_HDR = 2'h2;
  localparam RG_VAL = 2'h3;

  // Infopage storage, erased to all ones
  reg [31:0] otp_mem [0:`OTP_WORDS-1];
  reg [31:0] key_value [0:`VALUE_WORDS-1];
  reg [31:0] key_slot_permissions [0:`SLOTS-1];
  reg [31:0] key_push_destination [0:`SLOTS-1];

  reg [7:0] slot_select;
  reg [`ST_W-1:0] status;
  reg [`ST_W-1:0] int_mask;
  reg state;
  reg [1:0] push_idx;
  reg [6:0] push_slot;
  reg [31:0] push_base;

  integer i;

  // Infopage address decode
  reg [1:0] region;
  always @* begin
    region = RG_NONE;
    if (ip_addr_i[11:8] == `OTP_TAG) begin
      region = RG_OTP;
    end else if (ip_addr_i[11:10] == `HDR_TAG) begin
      region = RG_HDR;
    end else if (ip_addr_i[11]) begin
      region = RG_VAL;
    end else begin
      region = RG_NONE;
    end
  end
  wire is_otp = (region == RG_OTP);
  wire is_hdr = (region == RG_HDR);
  wire is_val = (region == RG_VAL);
  wire [5:0] otp_idx = ip_addr_i[7:2];
  wire [6:0] hdr_slot = ip_addr_i[9:3];
  wire hdr_is_push_destination = ip_addr_i[2];
  wire [6:0] val_slot = ip_addr_i[10:4];
  wire [8:0] val_idx = ip_addr_i[10:2];
  wire [6:0] acc_slot = is_val ? val_slot : hdr_slot;
  wire [7:0] sel_minus = slot_select - `SEL_ONE;
  wire [6:0] sel_slot = sel_minus[6:0];
  wire slot_match = (slot_select != `SEL_NONE) && (sel_minus == {1'b0, acc_slot});
  wire [31:0] acc_slot_permissions = key_slot_permissions[acc_slot];
  wire ip_req = ip_we_i | ip_re_i;

  // OTP write-once per halfword
  wire [31:0] otp_old = otp_mem[otp_idx];
  wire hi_keep = (ip_wdata_i[31:16] == `ERASED_HALF);
  wire lo_keep = (ip_wdata_i[15:0] == `ERASED_HALF);
  wire hi_free = (otp_old[31:16] == `ERASED_HALF);
  wire lo_free = (otp_old[15:0] == `ERASED_HALF);
  wire otp_ok = (hi_keep || hi_free) && (lo_keep || lo_free);
  wire [31:0] otp_merged = {hi_keep ? otp_old[31:16] : ip_wdata_i[31:16],
                            lo_keep ? otp_old[15:0] : ip_wdata_i[15:0]};

  reg ip_allow;
  reg ip_block;

  // Allow or block the infopage access
  always @* begin
    ip_allow = 1'b0;
    ip_block = 1'b0;
    if (ip_req) begin
      if (!ip_secure_i) begin
        ip_block = 1'b1;
      end else if (is_otp) begin
        ip_allow = ip_re_i | otp_ok;
        ip_block = ip_we_i & ~otp_ok;
      end else if (is_hdr) begin
        ip_allow = ip_re_i | (slot_match & acc_slot_permissions[`SLOT_PERMISSIONS_WRITE]);
        ip_block = ~ip_allow;
      end else if (is_val) begin
        if (ip_re_i) begin
          ip_allow = slot_match & acc_slot_permissions[`SLOT_PERMISSIONS_ACTIVE] & acc_slot_permissions[`SLOT_PERMISSIONS_READ];
        end else begin
          ip_allow = slot_match & acc_slot_permissions[`SLOT_PERMISSIONS_WRITE];
        end
        ip_block = ~ip_allow;
      end
    end
  end

  wire sel_event = ip_allow & (is_hdr | is_val) & slot_match;

  // Unit register port
  wire reg_req = reg_we_i | reg_re_i;
  wire reg_block = reg_req & ~reg_secure_i;
  wire reg_wr = reg_we_i & reg_secure_i;
  wire reg_rd = reg_re_i & reg_secure_i;
  wire push_req = reg_wr && (reg_addr_i == `REG_TASK_PUSH) && reg_wdata_i[0];
  wire [31:0] sel_slot_permissions = key_slot_permissions[sel_slot];
  wire [31:0] sel_push_destination = key_push_destination[sel_slot];
  wire push_ok = (state == ST_IDLE) && (slot_select != `SEL_NONE) &&
                 sel_slot_permissions[`SLOT_PERMISSIONS_ACTIVE] && sel_slot_permissions[`SLOT_PERMISSIONS_PUSH] &&
                 (sel_push_destination != `ERASED_WORD);
  wire push_start = push_req & push_ok;
  wire push_block = push_req & ~push_ok;
  wire push_done = (state == ST_PUSH) && (push_idx == `PUSH_LAST);

  // Sticky status; an event in the clearing cycle wins
  wire status_clear = reg_rd && (reg_addr_i == `REG_STATUS);
  reg [`ST_W-1:0] status_set;
  always @* begin
    status_set = {`ST_W{1'b0}};
    status_set[`ST_BLOCKED] = ip_block | reg_block | push_block;
    status_set[`ST_SELECTED] = sel_event;
    status_set[`ST_PUSH_DONE] = push_done;
  end
  wire [`ST_W-1:0] next_status = (status & ~{`ST_W{status_clear}}) | status_set;

  reg [31:0] next_reg_rdata;
  always @* begin
    next_reg_rdata = `ZERO_WORD;
    if (reg_re_i && !reg_secure_i) begin
      next_reg_rdata = `BLOCKED_WORD;
    end else if (reg_rd) begin
      case (reg_addr_i)
        `REG_STATUS: next_reg_rdata = {{(32-`ST_W){1'b0}}, status};
        `REG_INT_MASK: next_reg_rdata = {{(32-`ST_W){1'b0}}, int_mask};
        `REG_SLOT_SELECT: next_reg_rdata = {24'h00_0000, slot_select};
        default: next_reg_rdata = `ZERO_WORD;
      endcase
    end
  end

  reg [31:0] next_ip_rdata;
  always @* begin
    next_ip_rdata = `ZERO_WORD;
    if (ip_re_i) begin
      if (ip_block) begin
        next_ip_rdata = `BLOCKED_WORD;
      end else if (is_otp) begin
        next_ip_rdata = otp_old;
      end else if (is_hdr) begin
        next_ip_rdata = hdr_is_push_destination ? key_push_destination[hdr_slot] : key_slot_permissions[hdr_slot];
      end else if (is_val) begin
        next_ip_rdata = key_value[val_idx];
      end
    end
  end

  // Mask register update
  reg [`ST_W-1:0] next_int_mask;
  always @* begin
    next_int_mask = int_mask;
    if (reg_wr && (reg_addr_i == `REG_INT_MASK)) begin
      next_int_mask = reg_wdata_i[`ST_W-1:0];
    end
  end

  // Slot select update; out-of-range identifiers are ignored
  reg [7:0] next_slot_select;
  always @* begin
    next_slot_select = slot_select;
    if (reg_wr && (reg_addr_i == `REG_SLOT_SELECT) && (reg_wdata_i[31:8] == 24'h00_0000)
        && (reg_wdata_i[7:0] <= `SEL_MAX)) begin
      next_slot_select = reg_wdata_i[7:0];
    end
  end

  // Unit registers
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      slot_select <= `SEL_NONE;
      int_mask <= {`ST_W{1'b0}};
    end else begin
      slot_select <= next_slot_select;
      int_mask <= next_int_mask;
    end
  end

  // Sticky status
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      status <= {`ST_W{1'b0}};
    end else begin
      status <= next_status;
    end
  end

  // Level interrupt; a mask change acts at once
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_status & next_int_mask);
    end
  end

  // Read data, standing only in the answer cycle
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `ZERO_WORD;
      ip_rdata_o <= `ZERO_WORD;
    end else begin
      reg_rdata_o <= next_reg_rdata;
      ip_rdata_o <= next_ip_rdata;
    end
  end

  // Infopage storage updates, only on allowed writes
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < `OTP_WORDS; i = i + 1) begin
        otp_mem[i] <= `ERASED_WORD;
      end
      for (i = 0; i < `VALUE_WORDS; i = i + 1) begin
        key_value[i] <= `ERASED_WORD;
      end
      for (i = 0; i < `SLOTS; i = i + 1) begin
        key_slot_permissions[i] <= `ERASED_WORD;
        key_push_destination[i] <= `ERASED_WORD;
      end
    end else if (ip_we_i && ip_allow) begin
      if (is_otp) begin
        otp_mem[otp_idx] <= otp_merged;
      end else if (is_hdr) begin
        if (hdr_is_push_destination) begin
          key_push_destination[hdr_slot] <= ip_wdata_i;
        end else begin
          key_slot_permissions[hdr_slot] <= ip_wdata_i;
        end
      end else if (is_val) begin
        key_value[val_idx] <= ip_wdata_i;
      end
    end
  end

  // Push engine: four words to the slot's destination
  reg next_state;
  reg [1:0] next_push_idx;
  reg [6:0] next_push_slot;
  reg [31:0] next_push_base;
  reg next_push_valid;
  reg [31:0] next_push_addr;
  reg [31:0] next_push_data;
  always @* begin
    next_state = state;
    next_push_idx = push_idx;
    next_push_slot = push_slot;
    next_push_base = push_base;
    next_push_valid = 1'b0;
    next_push_addr = `ZERO_WORD;
    next_push_data = `ZERO_WORD;
    case (state)
      ST_IDLE: begin
        next_push_idx = `PUSH_FIRST;
        if (push_start) begin
          next_state = ST_PUSH;
          next_push_slot = sel_slot;
          next_push_base = sel_push_destination;
        end
      end
      ST_PUSH: begin
        next_push_valid = 1'b1;
        next_push_addr = push_base;
        next_push_data = key_value[{push_slot, push_idx}];
        next_push_base = push_base + `ADDR_STEP;
        next_push_idx = push_idx + `PUSH_STEP;
        if (push_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Push registers; the lines stay at zero while idle
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      push_idx <= `PUSH_FIRST;
      push_slot <= 7'h00;
      push_base <= `ZERO_WORD;
      push_valid_o <= 1'b0;
      push_addr_o <= `ZERO_WORD;
      push_data_o <= `ZERO_WORD;
    end else begin
      state <= next_state;
      push_idx <= next_push_idx;
      push_slot <= next_push_slot;
      push_base <= next_push_base;
      push_valid_o <= next_push_valid;
      push_addr_o <= next_push_addr;
      push_data_o <= next_push_data;
    end
  end

endmodule // key_slot_access_control

`default_nettype wire

// ### key_slot_checker_sva.sv
// Port checker for the key slot access control block.
// Sees only the block's ports; bound to every instance below.
`timescale 1ns/1ps
`default_nettype none
module key_slot_checker (
  input wire clk_i,
  input wire rst_n_i,
  input wire reg_we_i,
  input wire reg_re_i,
  input wire reg_secure_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_rdata_o,
  input wire ip_re_i,
  input wire ip_secure_i,
  input wire [31:0] ip_rdata_o,
  input wire push_valid_o,
  input wire [31:0] push_addr_o,
  input wire [31:0] push_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_burst;
    push_valid_o [*4] ##1 !push_valid_o;
  endsequence
  a_reg_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("register read data outside answer cycle");
  a_ip_rdata_idle: assert property (!$past(ip_re_i) |-> ip_rdata_o == 32'h0000_0000)
    else $error("infopage read data outside answer cycle");
  a_reg_nonsec_read: assert property (reg_re_i && !reg_secure_i |=> reg_rdata_o == 32'hDEAD_DEAD)
    else $error("non-secure register read not blocked");
  a_ip_nonsec_read: assert property (ip_re_i && !ip_secure_i |=> ip_rdata_o == 32'hDEAD_DEAD)
    else $error("non-secure infopage read not blocked");
  a_push_burst_len: assert property ($rose(push_valid_o) |-> s_burst)
    else $error("push burst is not four words");
  a_push_addr_step: assert property (push_valid_o && $past(push_valid_o) |->
    push_addr_o == $past(push_addr_o) + 32'h0000_0004)
    else $error("push address does not step by four");
  a_push_cause: assert property ($rose(push_valid_o) |-> $past(reg_we_i, 2) &&
    $past(reg_secure_i, 2) && $past(reg_addr_i, 2) == 8'h00)
    else $error("push without secure push request");
  a_push_idle_zero: assert property (!push_valid_o |->
    push_addr_o == 32'h0000_0000 && push_data_o == 32'h0000_0000)
    else $error("push lines driven while idle");
endmodule // key_slot_checker
bind key_slot_access_control key_slot_checker i_key_slot_checker (.*);
`default_nettype wire

// ### key_sink.sv
// Destination model: a write-only key register bank fed by the push lines.
// Assumes one word per valid cycle; keeps the last four words, slot chosen by arrival count modulo four.
`timescale 1ns/1ps
`default_nettype none
module key_sink (
  input wire clk_i,
  input wire valid_i,
  input wire [31:0] addr_i,
  input wire [31:0] data_i
);
  logic [31:0] adr [0:3];
  logic [31:0] dat [0:3];
  int n = 0;
  // Takes words only; nothing ever flows back
  always @(posedge clk_i) begin
    if (valid_i) begin
      adr[n[1:0]] <= addr_i;
      dat[n[1:0]] <= data_i;
      n <= n + 1;
    end
  end
endmodule // key_sink
`default_nettype wire

// ### key_slot_access_control_tb.sv
// Self-checking bench for the key slot access control block.
// Assumes the checker is bound and the key sink models the push destination.
`timescale 1ns/1ps
`default_nettype none
module key_slot_access_control_tb;
  typedef struct {logic [1:0] k; logic [11:0] a; logic [31:0] v; logic s;} row_t;
  logic clk_i, rst_n_i, reg_we_i, reg_re_i, reg_secure_i, ip_we_i, ip_re_i, ip_secure_i;
  logic irq_got;
  logic [7:0] reg_addr_i;
  logic [11:0] ip_addr_i;
  logic [31:0] reg_wdata_i, ip_wdata_i, got;
  wire [31:0] reg_rdata_o, ip_rdata_o, push_addr_o, push_data_o;
  wire push_valid_o, irq_o;
  int err_total, compares, i;
  // Kind: 0 ip write, 1 ip read, 2 reg write, 3 reg read
  row_t rows[29] = '{
    '{1, 12'h000, 32'hFFFF_FFFF, 1},
    '{0, 12'h000, 32'h1234_FFFF, 1},
    '{0, 12'h000, 32'hFFFF_AABB, 1},
    '{1, 12'h000, 32'h1234_AABB, 1},
    '{0, 12'h000, 32'h5678_FFFF, 1},
    '{1, 12'h000, 32'h1234_AABB, 1},
    '{3, 12'h004, 32'h0000_0001, 1},
    '{1, 12'h800, 32'hDEAD_DEAD, 1},
    '{1, 12'h400, 32'hFFFF_FFFF, 1},
    '{2, 12'h00C, 32'h0000_0001, 1},
    '{0, 12'h404, 32'h0000_2000, 1},
    '{0, 12'h800, 32'h0000_A000, 1},
    '{0, 12'h804, 32'h0000_A001, 1},
    '{0, 12'h808, 32'h0000_A002, 1},
    '{0, 12'h80C, 32'h0000_A003, 1},
    '{0, 12'h400, 32'h0001_0006, 1},
    '{0, 12'h800, 32'h0000_0000, 1},
    '{1, 12'h800, 32'h0000_A000, 1},
    '{1, 12'h80C, 32'hDEAD_DEAD, 0},
    '{3, 12'h004, 32'h0000_0003, 1},
    '{2, 12'h00C, 32'h0000_0002, 1},
    '{1, 12'h800, 32'hDEAD_DEAD, 1},
    '{2, 12'h00C, 32'h0000_0081, 1},
    '{3, 12'h00C, 32'h0000_0002, 1},
    '{3, 12'h010, 32'h0000_0000, 1},
    '{3, 12'h004, 32'hDEAD_DEAD, 0},
    '{3, 12'h004, 32'h0000_0001, 1},
    '{2, 12'h00C, 32'h0000_0001, 1},
    '{1, 12'h404, 32'h0000_2000, 1}
  };
  key_slot_access_control i_key_slot_access_control (.*);
  key_sink i_key_sink (.clk_i(clk_i), .valid_i(push_valid_o), .addr_i(push_addr_o),
    .data_i(push_data_o));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic [1:0] k, input logic [11:0] a, input logic [31:0] v,
    input logic s);
    ip_addr_i <= a;
    reg_addr_i <= a[7:0];
    ip_wdata_i <= v;
    reg_wdata_i <= v;
    ip_secure_i <= s;
    reg_secure_i <= s;
    ip_we_i <= (k == 2'd0);
    ip_re_i <= (k == 2'd1);
    reg_we_i <= (k == 2'd2);
    reg_re_i <= (k == 2'd3);
    @(posedge clk_i);
    {ip_we_i, ip_re_i, reg_we_i, reg_re_i} <= 4'h0;
    @(negedge clk_i);
    got = (k == 2'd1) ? ip_rdata_o : reg_rdata_o;
    irq_got = irq_o;
    @(posedge clk_i);
  endtask
  task summarize;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {rst_n_i, reg_we_i, reg_re_i, reg_secure_i, ip_we_i, ip_re_i, ip_secure_i} = 7'h00;
    {reg_addr_i, ip_addr_i, reg_wdata_i, ip_wdata_i} = 84'h0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1;
    foreach (rows[i]) begin
      op(rows[i].k, rows[i].a, rows[i].v, rows[i].s);
      if (rows[i].k[0]) chk(got, rows[i].v);
    end
    $display("table test done");
    op(2, 12'h008, 32'h0000_0001, 1);
    op(3, 12'h008, 32'h0000_0000, 1);
    chk(got, 32'h0000_0001);
    chk(32'(irq_got), 32'h0000_0000);
    op(1, 12'h800, 32'h0000_0000, 0);
    chk(32'(irq_got), 32'h0000_0001);
    op(3, 12'h004, 32'h0000_0000, 1);
    chk(got, 32'h0000_0003);
    chk(32'(irq_got), 32'h0000_0000);
    $display("interrupt test done");
    op(2, 12'h000, 32'h0000_0001, 1);
    for (i = 0; i < 20 && push_valid_o !== 1'b1; i++) @(negedge clk_i);
    if (i == 20) begin
      err_total++;
      summarize();
    end
    repeat (6) @(posedge clk_i);
    for (i = 0; i < 4; i++) begin
      chk(i_key_sink.adr[i], 32'h0000_2000 + 32'(4 * i));
      chk(i_key_sink.dat[i], 32'h0000_A000 + 32'(i));
    end
    op(3, 12'h004, 32'h0000_0000, 1);
    chk(got, 32'h0000_0004);
    op(2, 12'h000, 32'h0000_0001, 0);
    repeat (8) @(posedge clk_i);
    chk(32'(i_key_sink.n), 32'h0000_0004);
    $display("push test done");
    op(2, 12'h00C, 32'h0000_0000, 1);
    rst_n_i <= 0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1;
    op(3, 12'h00C, 32'h0000_0000, 1);
    chk(got, 32'h0000_0000);
    op(3, 12'h008, 32'h0000_0000, 1);
    chk(got, 32'h0000_0000);
    $display("reset test done");
    summarize();
  end
endmodule // key_slot_access_control_tb
`default_nettype wire
